//--- logic/sync_burst_sram_control.sv
/*
 * Control logic of a pipelined synchronous burst SRAM: input capture, cycle
 * decode, 2-bit burst counter, byte/global write gating, output register
 * and asynchronous output-enable gating of the data pins.
 * Assumes the storage array is outside: it takes mem_addr_o, mem_wr_lane_o
 * and mem_wdata_o, and returns mem_rdata_i combinationally for mem_addr_o.
 * Pin inputs are synchronous to clk_i; the pad combines data_o/data_oe_o.
 */
`timescale 1ns/1ps

// What this block does
// - Global write low writes all byte lanes regardless of other write inputs.
// - Address, data, selects, write and burst controls captured on rising edge only.
// - Chip select high gates the processor address strobe.
// - Selected only with all three selects active; else a controller strobe, or a processor strobe with chip select low, deselects.
// - Data pins driven only while output enable low, combinationally.
// - Advance low steps burst counter; high holds address as wait cycle.
// - Processor strobe with chip selected registers address and starts a read.
// - Controller strobe deselects or registers address, read or write by decode.
// - Order input low gives linear order, high gives interleaved; treated static.
// - Interleaved order XORs starting low bits with 01, 10, 11.
// - Linear order increments the two low bits modulo four.
// - Deselect cycles power down and float the data pins.
// - Controller strobe, selected, write decoded low begins a write burst.
// - Read burst begins on processor strobe, or controller strobe with write high.
// - No strobe and advance low continues burst at next address.
// - No strobe and advance high repeats the current address.
// - Write decoded from global write, or gate low with any lane low.
// - Byte-gated write updates only lanes whose lane write input is low.
// - Data pins float from power-up until a read with outputs enabled.
// - Narrow organization has two lanes, wide organization four.
// - Burst counter supplies the two lowest address bits during burst and wait.
// - Lane write inputs count only while byte gate is low.
module sync_burst_sram_control #(
    parameter bit NARROW_ORG = 1'b0
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // Address and selects
    input wire logic [sram_ctl_pkg::ADDR_W-1:0] addr_i,
    input wire logic chip_sel_n_i,
    input wire logic second_chip_sel_n_i,
    input wire logic second_chip_sel_i,
    // Burst controls
    input wire logic proc_addr_strobe_n_i,
    input wire logic ctrl_addr_strobe_n_i,
    input wire logic burst_advance_n_i,
    input wire logic burst_order_sel_i,
    // Write controls
    input wire logic global_write_n_i,
    input wire logic byte_write_gate_n_i,
    input wire logic [sram_ctl_pkg::LANES-1:0] lane_write_n_i,
    // Data pins, lane a in the low bits
    input wire logic out_enable_n_i,
    input wire logic [sram_ctl_pkg::DATA_W-1:0] data_i,
    output logic [sram_ctl_pkg::DATA_W-1:0] data_o,
    output logic [sram_ctl_pkg::LANES-1:0] data_oe_o,
    // Array side
    output logic [sram_ctl_pkg::ADDR_W-1:0] mem_addr_o,
    output logic [sram_ctl_pkg::LANES-1:0] mem_wr_lane_o,
    output logic [sram_ctl_pkg::DATA_W-1:0] mem_wdata_o,
    input wire logic [sram_ctl_pkg::DATA_W-1:0] mem_rdata_i,
    // Status
    output logic power_down_o
);
    localparam logic [3:0] LANE_MASK =
        NARROW_ORG ? sram_ctl_pkg::LANE_MASK_NARROW : sram_ctl_pkg::LANE_MASK_WIDE;

    sram_ctl_pkg::state_t state;
    sram_ctl_pkg::cycle_t cycle;
    logic selected;
    logic proc_start;
    logic write_n_dec;
    logic access_go;
    logic access_wr;
    logic [sram_ctl_pkg::LANES-1:0] lane_wr;
    logic [sram_ctl_pkg::ADDR_W-1:0] base_addr;
    logic [sram_ctl_pkg::ADDR_W-1:0] next_base;
    logic [1:0] count;
    logic [1:0] next_count;
    logic [1:0] next_low;
    logic read_pend;
    logic rd_valid;

    // Select and write decode from the sampled pins
    assign selected = !chip_sel_n_i && !second_chip_sel_n_i && second_chip_sel_i;
    assign proc_start = !proc_addr_strobe_n_i && !chip_sel_n_i;
    assign write_n_dec = global_write_n_i
        && (byte_write_gate_n_i || &(lane_write_n_i | ~LANE_MASK));

    // Cycle kind; the processor strobe takes priority and never writes
    always_comb begin
        cycle = sram_ctl_pkg::CYC_NONE;
        if (proc_start) begin
            cycle = selected ? sram_ctl_pkg::CYC_BEGIN : sram_ctl_pkg::CYC_DESELECT;
        end else if (!ctrl_addr_strobe_n_i) begin
            cycle = selected ? sram_ctl_pkg::CYC_BEGIN : sram_ctl_pkg::CYC_DESELECT;
        end else if (state == sram_ctl_pkg::ST_BURST) begin
            cycle = burst_advance_n_i ? sram_ctl_pkg::CYC_SUSPEND
                                      : sram_ctl_pkg::CYC_CONTINUE;
        end
    end

    // Access kind: processor strobe starts a read, other cycles follow the decode
    assign access_go = (cycle == sram_ctl_pkg::CYC_BEGIN)
        || (cycle == sram_ctl_pkg::CYC_CONTINUE) || (cycle == sram_ctl_pkg::CYC_SUSPEND);
    assign access_wr = !write_n_dec
        && !(cycle == sram_ctl_pkg::CYC_BEGIN && proc_start);

    // Per-lane write enables: global write wins, else gate plus lane input
    generate
        for (genvar i = 0; i < sram_ctl_pkg::LANES; i++) begin : g_lane
            assign lane_wr[i] = LANE_MASK[i] && access_go && access_wr
                && (!global_write_n_i
                    || (!byte_write_gate_n_i && !lane_write_n_i[i]));
        end
    endgenerate

    // Burst address: new start on a begin, counter otherwise supplies low bits
    always_comb begin
        next_base = base_addr;
        next_count = count;
        if (cycle == sram_ctl_pkg::CYC_BEGIN) begin
            next_base = addr_i;
            next_count = sram_ctl_pkg::COUNT_RST;
        end else if (cycle == sram_ctl_pkg::CYC_CONTINUE) begin
            next_count = 2'(count + sram_ctl_pkg::BURST_ONE);
        end
        if (burst_order_sel_i) begin
            next_low = next_base[sram_ctl_pkg::BURST_LSB +: sram_ctl_pkg::BURST_W]
                ^ next_count;
        end else begin
            next_low = 2'(next_base[sram_ctl_pkg::BURST_LSB +: sram_ctl_pkg::BURST_W]
                + next_count);
        end
    end

    // Burst state: begin enters a burst, deselect leaves it
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= sram_ctl_pkg::ST_IDLE;
        end else if (clk_en_i) begin
            if (cycle == sram_ctl_pkg::CYC_BEGIN) begin
                state <= sram_ctl_pkg::ST_BURST;
            end else if (cycle == sram_ctl_pkg::CYC_DESELECT) begin
                state <= sram_ctl_pkg::ST_IDLE;
            end
        end
    end

    // Address and counter registers, captured on the rising edge only
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            base_addr <= sram_ctl_pkg::ADDR_RST;
            count <= sram_ctl_pkg::COUNT_RST;
            mem_addr_o <= sram_ctl_pkg::ADDR_RST;
        end else if (clk_en_i && access_go) begin
            base_addr <= next_base;
            count <= next_count;
            mem_addr_o <= {next_base[sram_ctl_pkg::ADDR_W-1:sram_ctl_pkg::BURST_W],
                next_low};
        end
    end

    // Write strobes last one cycle per write; data is captured with them
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mem_wr_lane_o <= sram_ctl_pkg::LANES_OFF;
            mem_wdata_o <= sram_ctl_pkg::DATA_RST;
        end else if (clk_en_i) begin
            mem_wr_lane_o <= lane_wr;
            if (access_go && access_wr) begin
                mem_wdata_o <= data_i;
            end
        end
    end

    // Read pipeline: array read in the cycle after the edge, output register next
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            read_pend <= 1'b0;
            rd_valid <= 1'b0;
            data_o <= sram_ctl_pkg::DATA_RST;
        end else if (clk_en_i) begin
            read_pend <= access_go && !access_wr;
            rd_valid <= read_pend;
            if (read_pend) begin
                data_o <= mem_rdata_i;
            end
        end
    end

    // Power-down flag follows deselect until the next begin
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            power_down_o <= sram_ctl_pkg::POWER_DOWN_RST;
        end else if (clk_en_i) begin
            if (cycle == sram_ctl_pkg::CYC_DESELECT) begin
                power_down_o <= 1'b1;
            end else if (cycle == sram_ctl_pkg::CYC_BEGIN) begin
                power_down_o <= 1'b0;
            end
        end
    end

    // Output enable is combinational on purpose: the pin must float without a
    // clock edge. The controller must still raise it ahead of write data.
    assign data_oe_o = {sram_ctl_pkg::LANES{rd_valid && !out_enable_n_i}}
        & LANE_MASK;

    // All checks run in the one clock domain and stay quiet while reset is held
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence read_issue;
        clk_en_i && access_go && !access_wr ##1 clk_en_i;
    endsequence

    sequence burst_step;
        clk_en_i && state == sram_ctl_pkg::ST_BURST && ctrl_addr_strobe_n_i
            && !proc_start && !burst_advance_n_i;
    endsequence

    AST_GLOBAL_WRITE: assert property (
        clk_en_i && access_go && !proc_start && !global_write_n_i
        |=> mem_wr_lane_o == LANE_MASK)
        else $error("global write did not enable every lane");

    AST_OE_GATE: assert property (
        data_oe_o != sram_ctl_pkg::LANES_OFF |-> !out_enable_n_i && rd_valid)
        else $error("data pins driven without output enable or read data");

    AST_PROC_READ: assert property (
        clk_en_i && proc_start && selected
        |=> mem_wr_lane_o == sram_ctl_pkg::LANES_OFF && read_pend
            && mem_addr_o == $past(addr_i))
        else $error("processor strobe did not start a read at the external address");

    AST_CTRL_WRITE: assert property (
        clk_en_i && selected && proc_addr_strobe_n_i && !ctrl_addr_strobe_n_i && !write_n_dec
        |=> mem_wr_lane_o != sram_ctl_pkg::LANES_OFF && mem_addr_o == $past(addr_i))
        else $error("controller strobe write did not begin at the external address");

    AST_DESELECT: assert property (
        clk_en_i && cycle == sram_ctl_pkg::CYC_DESELECT ##1 clk_en_i
        |=> !rd_valid && data_oe_o == sram_ctl_pkg::LANES_OFF)
        else $error("deselect did not float the data pins");

    // Checked one edge after the deselect: a begin right behind it may clear the flag
    AST_POWER_DOWN: assert property (
        clk_en_i && cycle == sram_ctl_pkg::CYC_DESELECT |=> power_down_o)
        else $error("deselect did not enter power-down");

    AST_LINEAR_STEP: assert property (
        burst_step and !burst_order_sel_i
        |=> mem_addr_o[1:0] == 2'($past(mem_addr_o[1:0]) + sram_ctl_pkg::BURST_ONE))
        else $error("linear burst did not increment the low address bits");

    AST_INTERLEAVE_STEP: assert property (
        burst_step and burst_order_sel_i
        |=> mem_addr_o[1:0]
            == (base_addr[1:0] ^ 2'($past(count) + sram_ctl_pkg::BURST_ONE)))
        else $error("interleaved burst address is not start XOR count");

    AST_SUSPEND: assert property (
        clk_en_i && cycle == sram_ctl_pkg::CYC_SUSPEND |=> $stable(mem_addr_o))
        else $error("wait cycle moved the address");

    AST_BYTE_LANES: assert property (
        clk_en_i && access_go && access_wr && global_write_n_i && !byte_write_gate_n_i
        |=> mem_wr_lane_o == (~$past(lane_write_n_i) & LANE_MASK))
        else $error("byte-gated write touched the wrong lanes");

    AST_GATE_HIGH_READS: assert property (
        clk_en_i && access_go && global_write_n_i && byte_write_gate_n_i
        |=> mem_wr_lane_o == sram_ctl_pkg::LANES_OFF && read_pend)
        else $error("write with byte gate high and global write high");

    AST_READ_LATENCY: assert property (
        read_issue |=> rd_valid && data_o == $past(mem_rdata_i))
        else $error("read data not presented one edge after the array read");

    // Begin and capture checks; the gated-strobe check only means something in idle
    AST_CTRL_READ: assert property (
        clk_en_i && selected && proc_addr_strobe_n_i && !ctrl_addr_strobe_n_i && write_n_dec
        |=> read_pend && mem_wr_lane_o == sram_ctl_pkg::LANES_OFF
            && mem_addr_o == $past(addr_i))
        else $error("controller strobe read did not begin at the external address");

    AST_PROC_GATED: assert property (
        clk_en_i && chip_sel_n_i && ctrl_addr_strobe_n_i && state == sram_ctl_pkg::ST_IDLE
        |=> $stable(mem_addr_o) && mem_wr_lane_o == sram_ctl_pkg::LANES_OFF && !read_pend)
        else $error("processor strobe acted on while chip select was high");

    AST_WRITE_DATA: assert property (
        clk_en_i && access_go && access_wr |=> mem_wdata_o == $past(data_i))
        else $error("write data not captured at the write edge");

endmodule : sync_burst_sram_control

//--- logic/sram_ctl_pkg.sv
/*
 * Shared constants and types for the synchronous burst SRAM control block.
 * Assumes one rising-edge clock domain; the array itself sits outside.
 */
package sram_ctl_pkg;
    // Organization: address, lane and data widths
    localparam int ADDR_W = 18;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;
    localparam logic [3:0] LANE_MASK_WIDE = 4'hf;
    localparam logic [3:0] LANE_MASK_NARROW = 4'h3;
    // Burst address field position and counter
    localparam int BURST_LSB = 0;
    localparam int BURST_W = 2;
    localparam logic [1:0] BURST_ONE = 2'h1;
    // Reset values
    localparam logic [1:0] COUNT_RST = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 18'h0;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h0;
    localparam logic [3:0] LANES_OFF = 4'h0;
    localparam logic POWER_DOWN_RST = 1'b1;

    // Burst tracking state
    typedef enum {ST_IDLE, ST_BURST} state_t;
    // Cycle kind decoded at each clock edge
    typedef enum {CYC_NONE, CYC_DESELECT, CYC_BEGIN, CYC_CONTINUE, CYC_SUSPEND} cycle_t;
endpackage : sram_ctl_pkg

//--- verification/sram_array_model.sv
/*
 * Behavioural storage array behind the SRAM control block: per-lane writes
 * on the rising edge, combinational read of the addressed word.
 * Assumes the control block's array-side ports; only 64 words are kept.
 */
`timescale 1ns/1ps

module sram_array_model (
    // Clock
    input wire logic clk_i,
    // Array side of the control block
    input wire logic [17:0] addr_i,
    input wire logic [3:0] wr_lane_i,
    input wire logic [35:0] wdata_i,
    output logic [35:0] rdata_o
);
    // Small depth keeps the model cheap; upper address bits alias
    logic [35:0] mem [0:63] = '{default: 36'h0};

    // Lane-wise update, untouched lanes keep their contents
    always_ff @(posedge clk_i) begin
        for (int k = 0; k < 4; k++) begin
            if (wr_lane_i[k]) begin
                mem[addr_i[5:0]][k*9 +: 9] <= wdata_i[k*9 +: 9];
            end
        end
    end

    // Read is combinational, as the control block expects
    assign rdata_o = mem[addr_i[5:0]];
endmodule : sram_array_model

//--- verification/sync_burst_sram_control_tb.sv
/*
 * Self-checking bench for the SRAM control block: writes, byte writes,
 * pipelined reads, both burst orders, wait cycles and deselects.
 * Assumes the array model beside it and inputs driven 2 ns after each edge.
 */
`timescale 1ns/1ps

module sync_burst_sram_control_tb;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic clk_en = 1'b1;
    logic [17:0] addr_i = 18'h0;
    logic cs_n = 1'b0, cs2_n = 1'b0, cs2 = 1'b1, proc_n = 1'b1, ctrl_n = 1'b1;
    logic adv_n = 1'b1, order = 1'b1, gw_n = 1'b1, bwe_n = 1'b1, oe_n = 1'b1;
    logic [3:0] lanes_n = 4'hf;
    logic [35:0] data_i = 36'h0;
    logic [35:0] data_o, mem_wdata, mem_rdata;
    logic [3:0] data_oe, wr_lane;
    logic [17:0] mem_addr;
    logic pd;
    int n_mismatch = 0;
    int n_checks = 0;

    sync_burst_sram_control uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en),
        .addr_i(addr_i), .chip_sel_n_i(cs_n), .second_chip_sel_n_i(cs2_n),
        .second_chip_sel_i(cs2), .proc_addr_strobe_n_i(proc_n),
        .ctrl_addr_strobe_n_i(ctrl_n), .burst_advance_n_i(adv_n),
        .burst_order_sel_i(order), .global_write_n_i(gw_n), .byte_write_gate_n_i(bwe_n),
        .lane_write_n_i(lanes_n), .out_enable_n_i(oe_n), .data_i(data_i),
        .data_o(data_o), .data_oe_o(data_oe), .mem_addr_o(mem_addr),
        .mem_wr_lane_o(wr_lane), .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata),
        .power_down_o(pd));
    sram_array_model array (.clk_i(clk_i), .addr_i(mem_addr), .wr_lane_i(wr_lane),
        .wdata_i(mem_wdata), .rdata_o(mem_rdata));

    // 40 MHz clock
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    // Inputs always change 2 ns after the edge, away from sampling
    task tick;
        @(posedge clk_i);
        #2;
    endtask : tick
    task chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Output enable stays high outside reads so write data never collides
    task idle;
        {proc_n, ctrl_n, adv_n, gw_n, bwe_n, oe_n} = 6'h3f;
        {cs_n, cs2_n, cs2, lanes_n} = {3'h1, 4'hf};
    endtask : idle
    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    // Global write overrides a byte gate that selects one lane only
    task t_gwrite;
        addr_i = 18'h10;
        {ctrl_n, gw_n, bwe_n} = 3'h0;
        lanes_n = 4'he;
        data_i = 36'h123456789;
        tick;
        idle;
        chk("wr_lane", 36'hf, wr_lane);
        chk("mem_addr", 36'h10, mem_addr);
        chk("wdata", 36'h123456789, mem_wdata);
        chk("power_down", 36'h0, pd);
        tick;
        chk("wr_pulse", 36'h0, wr_lane);
    endtask : t_gwrite
    // Byte-gated write of lane b, then lane inputs without the gate
    task t_bwrite;
        addr_i = 18'h11;
        {ctrl_n, bwe_n} = 2'h0;
        lanes_n = 4'hd;
        data_i = 36'hfedcba987;
        tick;
        chk("byte_lane", 36'h2, wr_lane);
        // Strobe held low: a back-to-back begin with lane inputs but no gate
        bwe_n = 1'b1;
        lanes_n = 4'h0;
        addr_i = 18'h12;
        tick;
        idle;
        chk("ungated", 36'h0, wr_lane);
    endtask : t_bwrite
    // Processor strobe read, data one edge after the address
    task t_read(input logic [17:0] a, input logic [35:0] e);
        addr_i = a;
        {proc_n, oe_n} = 2'h0;
        tick;
        proc_n = 1'b1;
        chk("rd_addr", {18'h0, a}, mem_addr);
        tick;
        chk("rd_data", e, data_o);
        chk("oe_on", 36'hf, data_oe);
        // Output enable acts without a clock edge, so look 1 ns after it moves
        oe_n = 1'b1;
        #1;
        chk("oe_off", 36'h0, data_oe);
        tick;
    endtask : t_read
    // Four-word burst, wrap, wait cycle, then a write continue
    task t_burst(input logic ord, input logic [1:0] st);
        logic [1:0] lo;
        order = ord;
        addr_i = {16'h8, st};
        ctrl_n = 1'b0;
        tick;
        {ctrl_n, adv_n} = 2'h2;
        for (int k = 1; k <= 4; k++) begin
            lo = ord ? (st ^ k[1:0]) : (st + k[1:0]);
            tick;
            chk("burst_addr", {18'h0, 16'h8, lo}, mem_addr);
        end
        adv_n = 1'b1;
        tick;
        chk("wait_addr", {18'h0, 16'h8, st}, mem_addr);
        {adv_n, gw_n} = 2'h0;
        tick;
        idle;
        chk("cont_write", 36'hf, wr_lane);
    endtask : t_burst
    // Write in the wait cycle that follows a processor strobe
    task t_proc_write;
        addr_i = 18'h30;
        proc_n = 1'b0;
        tick;
        {proc_n, gw_n} = 2'h2;
        data_i = 36'h0aaaa5555;
        tick;
        idle;
        chk("pw_lane", 36'hf, wr_lane);
        chk("pw_addr", 36'h30, mem_addr);
    endtask : t_proc_write
    // Clock enable low freezes every register: a strobe is then not taken
    task t_freeze;
        clk_en = 1'b0;
        addr_i = 18'h3c;
        ctrl_n = 1'b0;
        tick;
        chk("frozen_addr", 36'h30, mem_addr);
        chk("frozen_data", 36'h0aaaa5555, data_o);
        clk_en = 1'b1;
        ctrl_n = 1'b1;
        tick;
    endtask : t_freeze
    // Bad select combinations power down; continue is then refused
    task t_desel;
        logic [2:0] bad [3] = '{3'h4, 3'h2, 3'h0};
        {proc_n, cs_n} = 2'h1;
        tick;
        chk("proc_gated", 36'h0, pd);
        for (int k = 0; k < 3; k++) begin
            {proc_n, ctrl_n, cs_n, cs2_n, cs2} = 5'h11;
            tick;
            {cs_n, cs2_n, cs2} = bad[k];
            {proc_n, ctrl_n} = {~k[0], k[0]};
            tick;
            chk("deselect", 36'h1, pd);
        end
        // Idle with chip select high: the processor strobe and advance must do nothing
        {proc_n, ctrl_n, adv_n, gw_n} = 4'h4;
        {cs_n, cs2_n, cs2} = 3'h5;
        tick;
        chk("idle_refused", 36'h0, wr_lane);
        chk("idle_pd", 36'h1, pd);
        tick;
    endtask : t_desel

    initial begin
        #200000;
        n_mismatch++;
        end_of_test;
    end

    initial begin
        repeat (8) @(posedge clk_i);
        #2;
        chk("reset_oe", 36'h0, data_oe);
        chk("reset_pd", 36'h1, pd);
        reset_n_i = 1;
        t_gwrite;
        t_bwrite;
        t_read(18'h10, 36'h123456789);
        t_read(18'h11, 36'hfedcba987 & 36'h00003fe00);
        t_burst(1'b0, 2'h1);
        t_burst(1'b1, 2'h1);
        t_burst(1'b1, 2'h2);
        t_burst(1'b0, 2'h3);
        t_proc_write;
        t_read(18'h30, 36'h0aaaa5555);
        t_freeze;
        t_desel;
        end_of_test;
    end
endmodule : sync_burst_sram_control_tb
